// ### shared/msbc_pkg.sv
package msbc_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int DATA_W  = 8;
	localparam int SP_AW   = 4;
	localparam int SP_DEPTH = 16;
	localparam int PAGE_W  = 2;
	localparam int PC_W    = 10;
	localparam int MAR_W   = 10;
	localparam int REG_AW  = 3;

	// ----------------------------------------------------------------
	// register port map and fields
	// ----------------------------------------------------------------
	localparam logic [REG_AW-1:0] REG_CTRL   = 3'h0;
	localparam logic [REG_AW-1:0] REG_FLAGS  = 3'h1;
	localparam logic [REG_AW-1:0] REG_PC_LO  = 3'h2;
	localparam logic [REG_AW-1:0] REG_PC_HI  = 3'h3;
	localparam logic [REG_AW-1:0] REG_MAR_LO = 3'h4;
	localparam logic [REG_AW-1:0] REG_MAR_HI = 3'h5;
	localparam logic [REG_AW-1:0] REG_BRANCH = 3'h6;
	localparam int CTRL_RUN_BIT = 0;
	localparam int FLAG_C_BIT   = 0;
	localparam int FLAG_Z_BIT   = 1;

	// ----------------------------------------------------------------
	// reset values and constants
	// ----------------------------------------------------------------
	localparam logic [PC_W-1:0]   PC_RST   = 10'h000;
	localparam logic [MAR_W-1:0]  MAR_RST  = 10'h000;
	localparam logic [DATA_W-1:0] BR_RST   = 8'h00;
	localparam logic [DATA_W-1:0] SP_RST   = 8'h00;
	localparam logic              RUN_RST  = 1'b1;
	localparam logic [DATA_W-1:0] Z_MATCH  = 8'hff;
	localparam logic [PC_W-1:0]   PC_STEP  = 10'h001;
	localparam logic [MAR_W-1:0]  MAR_STEP = 10'h001;

	// ----------------------------------------------------------------
	// decoded microinstruction fields
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_MOVE,
		OP_BRANCH_IMM,
		OP_BRANCH_COMPUTED,
		OP_COMPARE,
		OP_OFFSET_TO_BRANCH_REG,
		OP_OFFSET_TO_MEMORY,
		OP_CALL_SUBROUTINE,
		OP_RETURN_FROM_SUBROUTINE
	} msbc_op_type;

	typedef enum logic [2:0] {
		COND_ALWAYS,
		COND_CARRY,
		COND_ZERO,
		COND_BR0,
		COND_BR1,
		COND_BR4,
		COND_BR7
	} msbc_cond_type;

	typedef enum logic [2:0] {
		ALU_PASS_A_OPERAND,
		ALU_PASS_B_OPERAND,
		ALU_OR_FUNCTION,
		ALU_AND,
		ALU_XOR,
		ALU_ADD,
		ALU_SUB
	} msbc_alu_type;

	typedef enum logic [1:0] {
		SRC_BRANCH_REG,
		SRC_MEMORY,
		SRC_IMMEDIATE
	} msbc_src_type;

	typedef enum logic [1:0] {
		DST_NONE,
		DST_BRANCH_REG,
		DST_SCRATCH,
		DST_MEMORY
	} msbc_dst_type;

	typedef enum logic [1:0] {
		MAR_KEEP,
		MAR_LOAD_ADDRESS_PAGE,
		MAR_LOAD_ADDRESS_OFFSET,
		MAR_INCREMENT_ADDRESS
	} msbc_mar_type;

endpackage

// ### hdl/msbc_sequencer.sv
`timescale 1ns/1ps
// Functional notes
// RULE1: sixteen scratch words, four-bit select
// RULE2: two-bit page field picks one of four
// RULE3: computed offset from alu on operands
// RULE4: computed offset may pass one operand
// RULE5: carry branch taken if set, else step
// RULE6: zero-flag branch variant, same behaviour
// RULE7: branch on branch register bits 0,1,4,7
// RULE8: memory compare sets zero on equal
// RULE9: branch register compare sets carry, zero
// RULE10: immediate page offset into branch register
// RULE11: immediate page offset into memory word
// RULE12: call saves return offset, then jumps
// RULE13: software uses one scratch word per level
// RULE14: return jumps to page, scratch offset
// RULE15: zero flag set when move gives 377
// RULE16: page load copies result bits to mar
// RULE17: offset load writes low mar byte
// RULE18: increment after store at current address
// RULE19: computed branches leave state unchanged
// RULE20: target is page above page offset
module msbc_sequencer
	import msbc_pkg::*;
(
	input  wire logic                  i_core_clk,
	input  wire logic                  i_reset_n,
	input  wire logic                  i_instr_valid,
	input  wire msbc_op_type           i_op,
	input  wire msbc_cond_type         i_cond,
	input  wire msbc_alu_type          i_alu_func,
	input  wire msbc_src_type          i_src,
	input  wire msbc_dst_type          i_dest,
	input  wire msbc_mar_type          i_mar_opt,
	input  wire logic [SP_AW-1:0]      i_scratch_word_select,
	input  wire logic [PAGE_W-1:0]     i_target_page_select,
	input  wire logic [DATA_W-1:0]     i_target_offset,
	input  wire logic [DATA_W-1:0]     i_return_offset,
	input  wire logic                  i_call_with_return_target,
	input  wire logic [DATA_W-1:0]     i_imm_data,
	input  wire logic                  i_load_branch_imm,
	output logic                       o_instr_taken,
	output logic [PC_W-1:0]            o_control_store_addr,
	output logic [MAR_W-1:0]           o_mem_addr,
	input  wire logic [DATA_W-1:0]     i_mem_rdata,
	output logic                       o_mem_wr,
	output logic [MAR_W-1:0]           o_mem_waddr,
	output logic [DATA_W-1:0]          o_mem_wdata,
	input  wire logic [REG_AW-1:0]     i_reg_addr,
	input  wire logic [DATA_W-1:0]     i_reg_wdata,
	input  wire logic                  i_reg_wr,
	input  wire logic                  i_reg_rd,
	output logic [DATA_W-1:0]          o_reg_rdata
);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function automatic logic [DATA_W:0] alu_eval(input msbc_alu_type func,
		input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
		case (func)
			ALU_PASS_A_OPERAND: return {1'b0, a};
			ALU_PASS_B_OPERAND: return {1'b0, b};
			ALU_OR_FUNCTION:    return {1'b0, a | b};
			ALU_AND:            return {1'b0, a & b};
			ALU_XOR:            return {1'b0, a ^ b};
			ALU_ADD:            return {1'b0, a} + {1'b0, b};
			ALU_SUB:            return {1'b0, a} - {1'b0, b};
			default:            return '0;
		endcase
	endfunction

	function automatic logic cond_met(input msbc_cond_type c,
		input logic carry, input logic zero, input logic [DATA_W-1:0] br);
		case (c)
			COND_ALWAYS: return 1'b1;
			COND_CARRY:  return carry;
			COND_ZERO:   return zero;
			COND_BR0:    return br[0];
			COND_BR1:    return br[1];
			COND_BR4:    return br[4];
			COND_BR7:    return br[7];
			default:     return 1'b0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [PC_W-1:0]   pc_ff,      nxt_pc;
	logic [MAR_W-1:0]  mar_ff,     nxt_mar;
	logic [DATA_W-1:0] branch_ff,  nxt_branch;
	logic              carry_ff,   nxt_carry;
	logic              zero_ff,    nxt_zero;
	logic              run_ff,     nxt_run;
	logic              wr_ff,      nxt_wr;
	logic [MAR_W-1:0]  waddr_ff,   nxt_waddr;
	logic [DATA_W-1:0] wdata_ff,   nxt_wdata;
	logic [DATA_W-1:0] rdata_ff,   nxt_rdata;
	logic [DATA_W-1:0] scratch_ff [SP_DEPTH];
	logic              sp_we;
	logic [DATA_W-1:0] sp_wdata;

	logic              exec;
	logic [DATA_W-1:0] sp_word;
	logic [DATA_W-1:0] b_operand;
	logic [DATA_W:0]   alu_out;
	logic [PC_W-1:0]   pc_seq;
	logic [PC_W-1:0]   target;

	assign exec = i_instr_valid & run_ff;
	// RULE1: four-bit scratch select
	assign sp_word = scratch_ff[i_scratch_word_select];
	assign pc_seq  = pc_ff + PC_STEP;
	// RULE20: page above offset
	assign target = {i_target_page_select, i_target_offset};

	// ----------------------------------------------------------------
	// next-state computation
	// ----------------------------------------------------------------
	always_comb begin
		nxt_pc     = pc_ff;
		nxt_mar    = mar_ff;
		nxt_branch = branch_ff;
		nxt_carry  = carry_ff;
		nxt_zero   = zero_ff;
		nxt_run    = run_ff;
		nxt_wr     = 1'b0;
		nxt_waddr  = waddr_ff;
		nxt_wdata  = wdata_ff;
		sp_we      = 1'b0;
		case (i_src)
			SRC_MEMORY:    b_operand = i_mem_rdata;
			SRC_IMMEDIATE: b_operand = i_imm_data;
			default:       b_operand = branch_ff;
		endcase
		// RULE3: alu forms offset
		// RULE4: pass functions pick one operand
		alu_out = alu_eval(i_alu_func, sp_word, b_operand);
		sp_wdata   = alu_out[DATA_W-1:0];
		if (exec) begin
			nxt_pc = pc_seq;
			case (i_op)
				OP_MOVE: begin
					// RULE15: zero on all-ones result
					nxt_zero  = (alu_out[DATA_W-1:0] == Z_MATCH);
					nxt_carry = alu_out[DATA_W];
					case (i_dest)
						DST_BRANCH_REG: nxt_branch = alu_out[DATA_W-1:0];
						DST_SCRATCH:    sp_we = 1'b1;
						DST_MEMORY: begin
							// RULE18: store at current mar
							nxt_wr    = 1'b1;
							nxt_waddr = mar_ff;
							nxt_wdata = alu_out[DATA_W-1:0];
						end
						default: nxt_wr = 1'b0;
					endcase
					case (i_mar_opt)
						// RULE16: page bits from result
						MAR_LOAD_ADDRESS_PAGE:
							nxt_mar = {alu_out[PAGE_W-1:0],
								mar_ff[DATA_W-1:0]};
						// RULE17: low byte from result
						MAR_LOAD_ADDRESS_OFFSET:
							nxt_mar = {mar_ff[MAR_W-1:DATA_W],
								alu_out[DATA_W-1:0]};
						// RULE18: increment after store
						MAR_INCREMENT_ADDRESS:
							nxt_mar = mar_ff + MAR_STEP;
						default: nxt_mar = mar_ff;
					endcase
				end
				OP_BRANCH_IMM: begin
					// RULE5: carry, RULE6: zero, RULE7: bits
					if (cond_met(i_cond, carry_ff, zero_ff, branch_ff))
						nxt_pc = target;
				end
				OP_BRANCH_COMPUTED: begin
					// RULE2: page field; RULE19: no side effects
					if (cond_met(i_cond, carry_ff, zero_ff, branch_ff))
						nxt_pc = {i_target_page_select,
							alu_out[DATA_W-1:0]};
				end
				OP_COMPARE: begin
					// RULE8: memory compare
					// RULE9: branch register compare
					nxt_zero  = (b_operand == sp_word);
					nxt_carry = (b_operand < sp_word);
				end
				// RULE10: offset into branch register
				OP_OFFSET_TO_BRANCH_REG: nxt_branch = i_target_offset;
				OP_OFFSET_TO_MEMORY: begin
					// RULE11: offset into memory word
					nxt_wr    = 1'b1;
					nxt_waddr = mar_ff;
					nxt_wdata = i_target_offset;
				end
				OP_CALL_SUBROUTINE: begin
					// RULE12: save return, load imm, jump
					sp_we    = 1'b1;
					sp_wdata = i_call_with_return_target ?
						i_return_offset : pc_seq[DATA_W-1:0];
					if (i_load_branch_imm)
						nxt_branch = i_imm_data;
					nxt_pc = target;
				end
				// RULE14: return to page and scratch offset
				OP_RETURN_FROM_SUBROUTINE:
					nxt_pc = {i_target_page_select, sp_word};
				default: nxt_pc = pc_seq;
			endcase
		end
		if (i_reg_wr) begin
			case (i_reg_addr)
				REG_CTRL:   nxt_run = i_reg_wdata[CTRL_RUN_BIT];
				REG_FLAGS: begin
					nxt_carry = i_reg_wdata[FLAG_C_BIT];
					nxt_zero  = i_reg_wdata[FLAG_Z_BIT];
				end
				REG_BRANCH: nxt_branch = i_reg_wdata;
				default:    nxt_run = run_ff;
			endcase
		end
		nxt_rdata = '0;
		if (i_reg_rd) begin
			case (i_reg_addr)
				REG_CTRL:   nxt_rdata[CTRL_RUN_BIT] = run_ff;
				REG_FLAGS: begin
					nxt_rdata[FLAG_C_BIT] = carry_ff;
					nxt_rdata[FLAG_Z_BIT] = zero_ff;
				end
				REG_PC_LO:  nxt_rdata = pc_ff[DATA_W-1:0];
				REG_PC_HI:  nxt_rdata[PAGE_W-1:0] = pc_ff[PC_W-1:DATA_W];
				REG_MAR_LO: nxt_rdata = mar_ff[DATA_W-1:0];
				REG_MAR_HI:
					nxt_rdata[PAGE_W-1:0] = mar_ff[MAR_W-1:DATA_W];
				REG_BRANCH: nxt_rdata = branch_ff;
				default:    nxt_rdata = '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pc_ff     <= PC_RST;
			mar_ff    <= MAR_RST;
			branch_ff <= BR_RST;
			carry_ff  <= 1'b0;
			zero_ff   <= 1'b0;
			run_ff    <= RUN_RST;
			wr_ff     <= 1'b0;
			waddr_ff  <= MAR_RST;
			wdata_ff  <= SP_RST;
			rdata_ff  <= SP_RST;
			for (int i = 0; i < SP_DEPTH; i++) begin
				scratch_ff[i] <= SP_RST;
			end
		end else begin
			pc_ff     <= nxt_pc;
			mar_ff    <= nxt_mar;
			branch_ff <= nxt_branch;
			carry_ff  <= nxt_carry;
			zero_ff   <= nxt_zero;
			run_ff    <= nxt_run;
			wr_ff     <= nxt_wr;
			waddr_ff  <= nxt_waddr;
			wdata_ff  <= nxt_wdata;
			rdata_ff  <= nxt_rdata;
			if (sp_we)
				scratch_ff[i_scratch_word_select] <= sp_wdata;
		end
	end

	assign o_instr_taken        = exec;
	assign o_control_store_addr = pc_ff;
	assign o_mem_addr           = mar_ff;
	assign o_mem_wr             = wr_ff;
	assign o_mem_waddr          = waddr_ff;
	assign o_mem_wdata          = wdata_ff;
	assign o_reg_rdata          = rdata_ff;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	logic bus_wr_quiet;
	assign bus_wr_quiet = !i_reg_wr;
	property p_carry_not_taken;
		exec && i_op == OP_BRANCH_IMM && i_cond == COND_CARRY &&
			!carry_ff |=> pc_ff == $past(pc_ff) + PC_STEP;
	endproperty
	a_carry_not_taken: assert property (p_carry_not_taken) // RULE5
		else $error("carry branch did not fall through");
	property p_zero_taken;
		exec && i_op == OP_BRANCH_IMM && i_cond == COND_ZERO &&
			zero_ff |=> pc_ff == $past(target);
	endproperty
	a_zero_taken: assert property (p_zero_taken) // RULE6
		else $error("zero branch not taken");
	property p_bit7_branch;
		exec && i_op == OP_BRANCH_IMM && i_cond == COND_BR7 |=>
			pc_ff == ($past(branch_ff[7]) ? $past(target) :
				$past(pc_seq));
	endproperty
	a_bit7_branch: assert property (p_bit7_branch) // RULE7
		else $error("bit 7 branch wrong target");
	property p_mem_compare;
		exec && i_op == OP_COMPARE && i_src == SRC_MEMORY &&
			bus_wr_quiet |=>
			zero_ff == ($past(i_mem_rdata) == $past(sp_word));
	endproperty
	a_mem_compare: assert property (p_mem_compare) // RULE8
		else $error("memory compare zero flag wrong");
	property p_br_compare;
		exec && i_op == OP_COMPARE && i_src == SRC_BRANCH_REG &&
			bus_wr_quiet |=>
			carry_ff == ($past(branch_ff) < $past(sp_word)) &&
			branch_ff == $past(branch_ff);
	endproperty
	a_br_compare: assert property (p_br_compare) // RULE9
		else $error("branch register compare carry wrong");
	property p_call_saves;
		exec && i_op == OP_CALL_SUBROUTINE &&
			!i_call_with_return_target |=>
			scratch_ff[$past(i_scratch_word_select)] ==
				$past(pc_seq[DATA_W-1:0]) && pc_ff == $past(target);
	endproperty
	a_call_saves: assert property (p_call_saves) // RULE12
		else $error("call did not save return offset");
	property p_return_jump;
		exec && i_op == OP_RETURN_FROM_SUBROUTINE |=>
			pc_ff == {$past(i_target_page_select), $past(sp_word)};
	endproperty
	a_return_jump: assert property (p_return_jump) // RULE14
		else $error("return went to wrong address");
	property p_post_increment;
		exec && i_op == OP_MOVE && i_dest == DST_MEMORY &&
			i_mar_opt == MAR_INCREMENT_ADDRESS |=>
			o_mem_wr && o_mem_waddr == $past(mar_ff) &&
			mar_ff == $past(mar_ff) + MAR_STEP;
	endproperty
	a_post_increment: assert property (p_post_increment) // RULE18
		else $error("increment before store");
	property p_computed_quiet;
		exec && i_op == OP_BRANCH_COMPUTED && bus_wr_quiet |=>
			$stable(branch_ff) && $stable(carry_ff) &&
			$stable(zero_ff) && !o_mem_wr;
	endproperty
	a_computed_quiet: assert property (p_computed_quiet) // RULE19
		else $error("computed branch changed state");
	c_computed_taken: cover property (exec && i_op == OP_BRANCH_COMPUTED &&
		i_cond == COND_ALWAYS);
	c_call_return: cover property (exec && i_op == OP_CALL_SUBROUTINE
		##[1:20] exec && i_op == OP_RETURN_FROM_SUBROUTINE);
	c_compare_less: cover property (exec && i_op == OP_COMPARE ##1 carry_ff);

endmodule

// ### verif/msbc_sequencer_tb.sv
`timescale 1ns/1ps
module msbc_sequencer_tb
	import msbc_pkg::*;
;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic          clk = 1'b0;
	logic          rst_n = 1'b0;
	logic          vld = 1'b0;
	msbc_op_type   op = OP_MOVE;
	msbc_cond_type cnd = COND_ALWAYS;
	msbc_alu_type  fn = ALU_PASS_A_OPERAND;
	msbc_src_type  src = SRC_IMMEDIATE;
	msbc_dst_type  dst = DST_NONE;
	msbc_mar_type  mop = MAR_KEEP;
	logic [3:0]    sel = 4'h0;
	logic [1:0]    pg = 2'h0;
	logic [7:0]    off = 8'h00, rof = 8'h00, imm = 8'h00, mrd = 8'h00;
	logic          crt = 1'b0, lbi = 1'b0, rwr = 1'b0, rrd = 1'b0;
	logic [2:0]    ra = 3'h0;
	logic [7:0]    rwd = 8'h00;
	logic          taken, mwr;
	logic [9:0]    csa, ma, mwa;
	logic [7:0]    mwd, rdat;
	int            errors = 0, checks = 0;
	bit [7:0]      br, rv, xi, xm, xr;
	bit [7:0]      sp [16];
	bit [9:0]      pc, mar;
	bit            cf, zf, xc, xl;
	bit            run = 1'b1;

	always #12.5 clk = ~clk;

	msbc_sequencer u_msbc_sequencer (
		.i_core_clk               (clk),
		.i_reset_n                (rst_n),
		.i_instr_valid            (vld),
		.i_op                     (op),
		.i_cond                   (cnd),
		.i_alu_func               (fn),
		.i_src                    (src),
		.i_dest                   (dst),
		.i_mar_opt                (mop),
		.i_scratch_word_select    (sel),
		.i_target_page_select     (pg),
		.i_target_offset          (off),
		.i_return_offset          (rof),
		.i_call_with_return_target(crt),
		.i_imm_data               (imm),
		.i_load_branch_imm        (lbi),
		.o_instr_taken            (taken),
		.o_control_store_addr     (csa),
		.o_mem_addr               (ma),
		.i_mem_rdata              (mrd),
		.o_mem_wr                 (mwr),
		.o_mem_waddr              (mwa),
		.o_mem_wdata              (mwd),
		.i_reg_addr               (ra),
		.i_reg_wdata              (rwd),
		.i_reg_wr                 (rwr),
		.i_reg_rd                 (rrd),
		.o_reg_rdata              (rdat)
	);

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic rw(logic [2:0] a, logic [7:0] d);
		@(posedge clk);
		ra <= a;
		rwd <= d;
		rwr <= 1'b1;
		@(posedge clk);
		rwr <= 1'b0;
		if (a == REG_CTRL) run = d[0];
		if (a == REG_FLAGS) {zf, cf} = d[1:0];
		if (a == REG_BRANCH) br = d;
	endtask

	task automatic rr(logic [2:0] a, output logic [7:0] q);
		@(posedge clk);
		ra <= a;
		rrd <= 1'b1;
		@(posedge clk);
		rrd <= 1'b0;
		#1 q = rdat;
	endtask

	task automatic st();
		logic [7:0] q;
		rr(REG_FLAGS, q);
		chk("flags", q[1:0], {zf, cf});
		rr(REG_BRANCH, q);
		chk("branch", q, br);
	endtask

	// one instruction, with the model stepped beside it
	task automatic ins(msbc_op_type o, msbc_cond_type c, msbc_alu_type f,
		msbc_src_type s, msbc_dst_type d, msbc_mar_type m, int n, int p,
		int t);
		bit [7:0] b, r;
		bit [8:0] r9;
		bit [9:0] wa;
		bit       tk, w;
		b = s == SRC_BRANCH_REG ? br : s == SRC_MEMORY ? xm : xi;
		case (f)
		ALU_PASS_A_OPERAND: r9 = {1'b0, sp[n]};
		ALU_PASS_B_OPERAND: r9 = {1'b0, b};
		ALU_OR_FUNCTION:    r9 = {1'b0, sp[n] | b};
		ALU_AND:            r9 = {1'b0, sp[n] & b};
		ALU_XOR:            r9 = {1'b0, sp[n] ^ b};
		ALU_ADD:            r9 = {1'b0, sp[n]} + {1'b0, b};
		default:            r9 = {1'b0, sp[n]} - {1'b0, b};
		endcase
		r = r9[7:0];
		tk = c == COND_ALWAYS || c == COND_CARRY && cf ||
			c == COND_ZERO && zf || c == COND_BR0 && br[0] ||
			c == COND_BR1 && br[1] || c == COND_BR4 && br[4] ||
			c == COND_BR7 && br[7];
		@(posedge clk);
		vld <= 1'b1;
		op <= o;
		cnd <= c;
		fn <= f;
		src <= s;
		dst <= d;
		mop <= m;
		sel <= n[3:0];
		pg <= p[1:0];
		off <= t[7:0];
		imm <= xi;
		mrd <= xm;
		rof <= xr;
		crt <= xc;
		lbi <= xl;
		#1 chk("taken", taken, run);
		@(posedge clk);
		vld <= 1'b0;
		w = 1'b0;
		wa = mar;
		if (run) begin
			pc = pc + 10'h001;
			case (o)
			OP_MOVE: begin
				zf = r == 8'hff;
				cf = r9[8];
				if (d == DST_BRANCH_REG) br = r;
				if (d == DST_SCRATCH) sp[n] = r;
				w = d == DST_MEMORY;
				if (m == MAR_LOAD_ADDRESS_PAGE) mar[9:8] = r[1:0];
				if (m == MAR_LOAD_ADDRESS_OFFSET) mar[7:0] = r;
				if (m == MAR_INCREMENT_ADDRESS) mar = mar + 10'h001;
			end
			OP_BRANCH_IMM: if (tk) pc = {p[1:0], t[7:0]};
			OP_BRANCH_COMPUTED: if (tk) pc = {p[1:0], r};
			OP_COMPARE: begin
				zf = b == sp[n];
				cf = b < sp[n];
			end
			OP_OFFSET_TO_BRANCH_REG: br = t[7:0];
			OP_OFFSET_TO_MEMORY: begin
				w = 1'b1;
				r = t[7:0];
			end
			OP_CALL_SUBROUTINE: begin
				sp[n] = xc ? xr : pc[7:0];
				if (xl) br = xi;
				pc = {p[1:0], t[7:0]};
			end
			default: pc = {p[1:0], sp[n]};
			endcase
		end
		#1;
		chk("pc", csa, pc);
		chk("mar", ma, mar);
		chk("mem_wr", mwr, w);
		if (w) begin
			chk("waddr", mwa, wa);
			chk("wdata", mwd, r);
		end
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		give_verdict();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] q;
		rv = 8'($urandom(48995));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rw(REG_PC_LO, 8'h5a);
		rw(3'h7, 8'h5a);
		for (int a = 0; a < 8; a++) begin
			rr(a[2:0], q);
			chk("reg", q, a == 0);
		end
		$display("test registers done");
		for (int k = 0; k < 28; k++) begin
			rv = 8'($urandom);
			rw(REG_FLAGS, rv);
			rv = 8'($urandom);
			rw(REG_BRANCH, rv);
			rv = 8'($urandom);
			ins(OP_BRANCH_IMM, msbc_cond_type'(k % 7), ALU_PASS_A_OPERAND,
				SRC_IMMEDIATE, DST_NONE, MAR_KEEP, 0, k % 4, rv);
		end
		$display("test immediate branches done");
		for (int k = 0; k < 42; k++) begin
			xi = 8'($urandom);
			xm = 8'($urandom);
			ins(OP_MOVE, COND_ALWAYS, ALU_PASS_B_OPERAND, SRC_IMMEDIATE,
				DST_SCRATCH, MAR_KEEP, k % 16, 0, 0);
			rv = 8'($urandom);
			rw(REG_FLAGS, rv);
			rv = 8'($urandom);
			rw(REG_BRANCH, rv);
			ins(OP_BRANCH_COMPUTED, msbc_cond_type'(k % 7),
				msbc_alu_type'(k / 6), k % 2 ? SRC_MEMORY : SRC_BRANCH_REG,
				DST_NONE, MAR_KEEP, k % 16, k % 4, 0);
			st();
		end
		$display("test computed branches done");
		for (int k = 0; k < 16; k++) begin
			xi = k == 0 ? 8'hff : 8'($urandom % 4);
			ins(OP_MOVE, COND_ALWAYS, ALU_PASS_B_OPERAND, SRC_IMMEDIATE,
				DST_SCRATCH, MAR_KEEP, k, 0, 0);
			st();
			xm = 8'($urandom % 4);
			rw(REG_BRANCH, 8'($urandom % 4));
			ins(OP_COMPARE, COND_ALWAYS, ALU_PASS_A_OPERAND,
				k % 2 ? SRC_MEMORY : SRC_BRANCH_REG, DST_NONE, MAR_KEEP,
				k, 0, 0);
			st();
		end
		$display("test compares done");
		// every alu function moved into the branch register
		for (int k = 0; k < 14; k++) begin
			xi = 8'($urandom);
			ins(OP_MOVE, COND_ALWAYS, msbc_alu_type'(k % 7), SRC_IMMEDIATE,
				DST_BRANCH_REG, MAR_KEEP, k, 0, 0);
			st();
		end
		$display("test alu moves done");
		xi = 8'h07;
		ins(OP_MOVE, COND_ALWAYS, ALU_PASS_B_OPERAND, SRC_IMMEDIATE,
			DST_NONE, MAR_LOAD_ADDRESS_PAGE, 0, 0, 0);
		xi = 8'hff;
		ins(OP_MOVE, COND_ALWAYS, ALU_PASS_B_OPERAND, SRC_IMMEDIATE,
			DST_NONE, MAR_LOAD_ADDRESS_OFFSET, 0, 0, 0);
		xi = 8'($urandom);
		ins(OP_MOVE, COND_ALWAYS, ALU_PASS_B_OPERAND, SRC_IMMEDIATE,
			DST_MEMORY, MAR_INCREMENT_ADDRESS, 0, 0, 0);
		rv = 8'($urandom);
		ins(OP_OFFSET_TO_MEMORY, COND_ALWAYS, ALU_PASS_A_OPERAND,
			SRC_IMMEDIATE, DST_NONE, MAR_KEEP, 0, 0, rv);
		rv = 8'($urandom);
		ins(OP_OFFSET_TO_BRANCH_REG, COND_ALWAYS, ALU_PASS_A_OPERAND,
			SRC_IMMEDIATE, DST_NONE, MAR_KEEP, 0, 0, rv);
		st();
		$display("test memory address done");
		// one scratch word per nested call level
		xl = 1'b1;
		xi = 8'($urandom);
		ins(OP_CALL_SUBROUTINE, COND_ALWAYS, ALU_PASS_A_OPERAND,
			SRC_IMMEDIATE, DST_NONE, MAR_KEEP, 5, 3, 8'h40);
		xl = 1'b0;
		xc = 1'b1;
		xr = 8'h9c;
		ins(OP_CALL_SUBROUTINE, COND_ALWAYS, ALU_PASS_A_OPERAND,
			SRC_IMMEDIATE, DST_NONE, MAR_KEEP, 6, 1, 8'h80);
		xc = 1'b0;
		ins(OP_RETURN_FROM_SUBROUTINE, COND_ALWAYS, ALU_PASS_A_OPERAND,
			SRC_IMMEDIATE, DST_NONE, MAR_KEEP, 6, 2, 0);
		ins(OP_RETURN_FROM_SUBROUTINE, COND_ALWAYS, ALU_PASS_A_OPERAND,
			SRC_IMMEDIATE, DST_NONE, MAR_KEEP, 5, 0, 0);
		st();
		$display("test calls done");
		rw(REG_CTRL, 8'h00);
		ins(OP_BRANCH_IMM, COND_ALWAYS, ALU_PASS_A_OPERAND, SRC_IMMEDIATE,
			DST_NONE, MAR_KEEP, 0, 1, 8'h11);
		rw(REG_CTRL, 8'h01);
		rr(REG_CTRL, q);
		chk("ctrl", q, 8'h01);
		$display("test halted core done");
		give_verdict();
	end
endmodule
